//--- hdl/esd_cfg_if.sv
`timescale 1ns/1ns
interface esd_cfg_if;
    logic       global_en;
    logic       high_en;
    logic       seg_en;
    logic [1:0] seg_size;
    logic [3:0] seg_top;

    modport owner   (output global_en, output high_en, output seg_en, output seg_size, output seg_top);
    modport decoder (input global_en, input high_en, input seg_en, input seg_size, input seg_top);
endinterface : esd_cfg_if

//--- hdl/esd_defines.svh
`ifndef ESD_DEFINES_SVH
`define ESD_DEFINES_SVH

// Configuration space byte offsets.
`define ESD_OFF_ERR        8'h60
`define ESD_OFF_CTL        8'h61
`define ESD_OFF_EXT        8'h62
`define ESD_OFF_TOP        8'h63

// Extended control register field positions.
`define ESD_EXT_HIGH       7
`define ESD_EXT_MONO       6
`define ESD_EXT_GLOBAL     3
`define ESD_EXT_SIZE_HI    2
`define ESD_EXT_SIZE_LO    1
`define ESD_EXT_SEGEN      0
`define ESD_EXT_WMASK      8'h8f
`define ESD_EXT_RESET      8'h00

// Space control register field positions and values.
`define ESD_CTL_OPEN       6
`define ESD_CTL_LOCK       4
`define ESD_CTL_BASESEG    3'h2

// Error status register field position.
`define ESD_ERR_FLAG       7

// Segment top field.
`define ESD_TOP_RESET      4'h1
`define ESD_TOP_LOW_ZERO   28'h0000000

// Address ranges.
`define ESD_COMPAT_BASE    40'h00000a0000
`define ESD_COMPAT_LAST    40'h00000bffff
`define ESD_HIGH_BASE      40'h00feda0000
`define ESD_HIGH_LAST      40'h00fedbffff
`define ESD_ABOVE_4G_ZERO  8'h00

// Protected segment sizes, 33 bits wide for the wrap-free compare.
`define ESD_SIZE_512K      33'h000080000
`define ESD_SIZE_1M        33'h000100000
`define ESD_SIZE_2M        33'h000200000
`define ESD_SIZE_4M        33'h000400000

`endif

//--- hdl/esd_pkg.sv
package esd_pkg;

    typedef logic [39:0] esd_addr_t;
    typedef logic [7:0]  esd_byte_t;

    typedef enum logic [1:0] {
        esd_route_pass,
        esd_route_dram,
        esd_route_io
    } esd_route_t;

endpackage : esd_pkg

//--- hdl/esd_range_decode.sv
`timescale 1ns/1ns
`include "esd_defines.svh"
module esd_range_decode (
    esd_cfg_if.decoder         cfg,
    input  wire esd_pkg::esd_addr_t addr,
    output logic               compat_hit,
    output logic               high_hit,
    output logic               seg_hit,
    output esd_pkg::esd_addr_t high_remap
);
    logic [32:0] seg_top_addr;
    logic [32:0] seg_size_bytes;
    logic [32:0] seg_base;
    logic [32:0] addr_low;

    assign seg_top_addr = {1'b0, cfg.seg_top, `ESD_TOP_LOW_ZERO};
    assign addr_low     = {1'b0, addr[31:0]};

    always_comb begin
        unique case (cfg.seg_size)
            2'h0: seg_size_bytes = `ESD_SIZE_512K;
            2'h1: seg_size_bytes = `ESD_SIZE_1M;
            2'h2: seg_size_bytes = `ESD_SIZE_2M;
            2'h3: seg_size_bytes = `ESD_SIZE_4M;
        endcase
    end

    // A top below the size wraps the base high, so nothing matches.
    assign seg_base = seg_top_addr - seg_size_bytes;

    assign compat_hit = cfg.global_en && addr >= `ESD_COMPAT_BASE && addr <= `ESD_COMPAT_LAST;

    assign high_hit = cfg.global_en && cfg.high_en && addr >= `ESD_HIGH_BASE && addr <= `ESD_HIGH_LAST;

    assign high_remap = addr - `ESD_HIGH_BASE + `ESD_COMPAT_BASE;

    assign seg_hit = cfg.global_en && cfg.seg_en && addr[39:32] == `ESD_ABOVE_4G_ZERO
                     && addr_low >= seg_base && addr_low < seg_top_addr;

endmodule : esd_range_decode

//--- hdl/esd_top.sv
// Function
// - Enabled high window remaps onto legacy DRAM for flagged requests, or any request while space is open.
// - Lock freezes enables, size and top.
// - Mono adapter bit reads zero, ignored.
// - Global enable exposes compatible window in sysmgmt.
// - No extended function without global enable.
// - Size field selects 512k to 4M.
// - Segment reaches DRAM for flagged requests, or any request while space is open.
// - Unflagged segment requests go to I/O port unless space is open.
// - Segment decodes only with both enables.
// - Top field gives address bits 31:28.
// - Segment is below 4G, base to top.
// - Top field resets to one.
// - Top rewritable any time until locked.
// - Lock set by write, cleared by reset.
// - Open unlocked space admits unflagged requests.
// - Unflagged non-writeback high or segment access sets error unless space is open.
`timescale 1ns/1ns
`include "esd_defines.svh"
module esd_top (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               cfg_wr_en,
    input  wire logic               cfg_rd_en,
    input  wire esd_pkg::esd_byte_t cfg_addr,
    input  wire esd_pkg::esd_byte_t cfg_wdata,
    output esd_pkg::esd_byte_t      cfg_rdata,
    output logic                    cfg_rvalid,
    input  wire logic               req_valid,
    input  wire esd_pkg::esd_addr_t req_addr,
    input  wire logic               req_sysmgmt_flag,
    input  wire logic               req_writeback,
    output logic                    rsp_valid,
    output logic                    rsp_dram,
    output logic                    rsp_io,
    output logic                    rsp_claimed,
    output esd_pkg::esd_addr_t      rsp_addr,
    output logic                    invalid_sysmgmt_access_flag
);

    esd_pkg::esd_byte_t  ext_ctl_ff;
    logic [3:0]          seg_top_ff;
    logic                sysmgmt_space_lock_ff;
    logic                space_open_ff;
    logic                err_ff;
    logic                nxt_err;
    esd_pkg::esd_byte_t  cfg_rdata_ff;
    esd_pkg::esd_byte_t  nxt_cfg_rdata;
    logic                cfg_rvalid_ff;
    logic                rsp_valid_ff;
    esd_pkg::esd_route_t route_ff;
    esd_pkg::esd_route_t nxt_route;
    logic                rsp_claimed_ff;
    esd_pkg::esd_addr_t  rsp_addr_ff;
    esd_pkg::esd_addr_t  nxt_rsp_addr;

    logic                wr_err;
    logic                wr_ctl;
    logic                wr_ext;
    logic                wr_top;
    logic                lock_write;
    logic                open_eff;
    logic                access_ok;
    logic                compat_hit;
    logic                high_hit;
    logic                seg_hit;
    logic                guarded_hit;
    logic                err_set;
    esd_pkg::esd_addr_t  high_remap;

    esd_cfg_if cfg_bus ();

    assign wr_err     = cfg_wr_en && cfg_addr == `ESD_OFF_ERR;
    assign wr_ctl     = cfg_wr_en && cfg_addr == `ESD_OFF_CTL;
    assign wr_ext     = cfg_wr_en && cfg_addr == `ESD_OFF_EXT;
    assign wr_top     = cfg_wr_en && cfg_addr == `ESD_OFF_TOP;
    assign lock_write = wr_ctl && cfg_wdata[`ESD_CTL_LOCK];

    assign cfg_bus.global_en = ext_ctl_ff[`ESD_EXT_GLOBAL];
    assign cfg_bus.high_en   = ext_ctl_ff[`ESD_EXT_HIGH];
    assign cfg_bus.seg_en    = ext_ctl_ff[`ESD_EXT_SEGEN];
    assign cfg_bus.seg_size  = ext_ctl_ff[`ESD_EXT_SIZE_HI:`ESD_EXT_SIZE_LO];
    assign cfg_bus.seg_top   = seg_top_ff;

    esd_range_decode u_decode (
        .cfg        (cfg_bus),
        .addr       (req_addr),
        .compat_hit (compat_hit),
        .high_hit   (high_hit),
        .seg_hit    (seg_hit),
        .high_remap (high_remap)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            ext_ctl_ff <= `ESD_EXT_RESET;
        end else if (wr_ext && !sysmgmt_space_lock_ff) begin
            ext_ctl_ff <= cfg_wdata & `ESD_EXT_WMASK;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            seg_top_ff <= `ESD_TOP_RESET;
        end else if (wr_top && !sysmgmt_space_lock_ff) begin
            seg_top_ff <= cfg_wdata[3:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sysmgmt_space_lock_ff <= 1'b0;
        end else if (lock_write) begin
            sysmgmt_space_lock_ff <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            space_open_ff <= 1'b0;
        end else if (sysmgmt_space_lock_ff || lock_write) begin
            space_open_ff <= 1'b0;
        end else if (wr_ctl) begin
            space_open_ff <= cfg_wdata[`ESD_CTL_OPEN];
        end
    end

    assign open_eff    = space_open_ff && !sysmgmt_space_lock_ff;
    assign access_ok   = req_sysmgmt_flag || open_eff;
    assign guarded_hit = high_hit || seg_hit;

    assign err_set = req_valid && guarded_hit && !req_sysmgmt_flag && !space_open_ff && !req_writeback;

    // A new error in the clearing cycle survives the clear.
    always_comb begin
        nxt_err = err_set || (err_ff && !(wr_err && cfg_wdata[`ESD_ERR_FLAG]));
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= nxt_err;
        end
    end

    always_comb begin
        nxt_cfg_rdata = 8'h00;
        unique case (cfg_addr)
            `ESD_OFF_ERR: nxt_cfg_rdata[`ESD_ERR_FLAG] = err_ff;
            `ESD_OFF_CTL: begin
                nxt_cfg_rdata[`ESD_CTL_OPEN] = space_open_ff;
                nxt_cfg_rdata[`ESD_CTL_LOCK] = sysmgmt_space_lock_ff;
                nxt_cfg_rdata[2:0]           = `ESD_CTL_BASESEG;
            end
            `ESD_OFF_EXT: nxt_cfg_rdata = ext_ctl_ff;
            `ESD_OFF_TOP: nxt_cfg_rdata[3:0] = seg_top_ff;
            default:      nxt_cfg_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_rdata_ff  <= 8'h00;
            cfg_rvalid_ff <= 1'b0;
        end else begin
            cfg_rvalid_ff <= cfg_rd_en;
            if (cfg_rd_en) begin
                cfg_rdata_ff <= nxt_cfg_rdata;
            end
        end
    end

    always_comb begin
        nxt_route    = esd_pkg::esd_route_pass;
        nxt_rsp_addr = req_addr;
        if (compat_hit || guarded_hit) begin
            nxt_route = access_ok ? esd_pkg::esd_route_dram : esd_pkg::esd_route_io;
        end
        if (high_hit && access_ok) begin
            nxt_rsp_addr = high_remap;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rsp_valid_ff   <= 1'b0;
            route_ff       <= esd_pkg::esd_route_pass;
            rsp_claimed_ff <= 1'b0;
            rsp_addr_ff    <= '0;
        end else begin
            rsp_valid_ff <= req_valid;
            if (req_valid) begin
                route_ff       <= nxt_route;
                rsp_claimed_ff <= compat_hit || guarded_hit;
                rsp_addr_ff    <= nxt_rsp_addr;
            end
        end
    end

    assign cfg_rdata                   = cfg_rdata_ff;
    assign cfg_rvalid                  = cfg_rvalid_ff;
    assign rsp_valid                   = rsp_valid_ff;
    assign rsp_dram                    = rsp_valid_ff && route_ff == esd_pkg::esd_route_dram;
    assign rsp_io                      = rsp_valid_ff && route_ff == esd_pkg::esd_route_io;
    assign rsp_claimed                 = rsp_valid_ff && rsp_claimed_ff;
    assign rsp_addr                    = rsp_addr_ff;
    assign invalid_sysmgmt_access_flag = err_ff;

endmodule : esd_top

//--- test/esd_fsb_agent.sv
`timescale 1ns/1ns
module esd_fsb_agent (
    input  wire logic          clock,
    output logic               req_valid,
    output esd_pkg::esd_addr_t req_addr,
    output logic               req_sysmgmt_flag,
    output logic               req_writeback
);
    initial begin
        req_valid = 1'b0;
        req_addr = '0;
        req_sysmgmt_flag = 1'b0;
        req_writeback = 1'b0;
    end
    // One request lasts one cycle; idle lines show inverted values.
    task automatic issue(input esd_pkg::esd_addr_t a, input logic f, input logic w);
        @(posedge clock);
        req_valid <= 1'b1;
        req_addr <= a;
        req_sysmgmt_flag <= f;
        req_writeback <= w;
        @(posedge clock);
        req_valid <= 1'b0;
        req_addr <= ~a;
        req_sysmgmt_flag <= ~f;
        req_writeback <= ~w;
    endtask : issue
endmodule : esd_fsb_agent

//--- test/esd_props.sv
`timescale 1ns/1ns
module esd_props (
    input wire logic               clock,
    input wire logic               rst,
    input wire esd_pkg::esd_byte_t cfg_addr,
    input wire esd_pkg::esd_byte_t cfg_rdata,
    input wire logic               cfg_rvalid,
    input wire logic               req_valid,
    input wire esd_pkg::esd_addr_t req_addr,
    input wire logic               req_sysmgmt_flag,
    input wire logic               rsp_valid,
    input wire logic               rsp_dram,
    input wire logic               rsp_io,
    input wire logic               rsp_claimed,
    input wire esd_pkg::esd_addr_t rsp_addr,
    input wire logic               invalid_sysmgmt_access_flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    rsp_follow_a: assert property (req_valid |=> rsp_valid)
        else $error("no response after request");
    rsp_idle_a: assert property (!req_valid |=> !rsp_valid && !rsp_dram && !rsp_io)
        else $error("response without request");
    route_excl_a: assert property (rsp_valid |-> (rsp_dram ^ rsp_io) == rsp_claimed)
        else $error("bad route combination");
    flag_dram_a: assert property (req_valid && req_sysmgmt_flag |=> !rsp_io)
        else $error("flagged request sent to io");
    high_remap_a: assert property (req_valid && req_sysmgmt_flag && req_addr >= 40'h00feda0000
        && req_addr <= 40'h00fedbffff |=> !rsp_claimed || rsp_addr == $past(req_addr) - 40'h00fed00000)
        else $error("high window remap wrong");
    above_4g_a: assert property (req_valid && req_addr[39:32] != 8'h00 |=> !rsp_claimed)
        else $error("claim above 4G");
    err_cause_a: assert property ($rose(invalid_sysmgmt_access_flag) |-> rsp_io && !$past(req_sysmgmt_flag))
        else $error("error flag without cause");
    mono_zero_a: assert property (cfg_rvalid && $past(cfg_addr) == 8'h62 |-> cfg_rdata[6:4] == 3'h0)
        else $error("mono or reserved bit set");
    top_read_a: assert property (cfg_rvalid && $past(cfg_addr) == 8'h63 |-> cfg_rdata[7:4] == 4'h0)
        else $error("top reserved bits set");
    cover property (req_valid && req_sysmgmt_flag ##1 rsp_dram);
    cover property ($rose(invalid_sysmgmt_access_flag));
    cover property (req_valid && !req_sysmgmt_flag ##1 rsp_dram);
endmodule : esd_props
bind esd_top esd_props u_props (.clock(clock), .rst(rst), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .req_valid(req_valid), .req_addr(req_addr), .req_sysmgmt_flag(req_sysmgmt_flag),
    .rsp_valid(rsp_valid), .rsp_dram(rsp_dram), .rsp_io(rsp_io), .rsp_claimed(rsp_claimed),
    .rsp_addr(rsp_addr), .invalid_sysmgmt_access_flag(invalid_sysmgmt_access_flag));

//--- test/extended_smram_decode_test.sv
`timescale 1ns/1ns
module extended_smram_decode_test;
    typedef struct packed {
        logic [39:0] addr;
        logic        flag;
        logic        wb;
        logic [2:0]  route;
        logic [39:0] exp_addr;
    } esd_row_t;
    logic clock = 1'b0, rst = 1'b1, cfg_wr_en = 1'b0, cfg_rd_en = 1'b0, cfg_rvalid, req_valid;
    logic req_sysmgmt_flag, req_writeback, rsp_valid, rsp_dram, rsp_io, rsp_claimed, err_flag;
    esd_pkg::esd_byte_t cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
    esd_pkg::esd_addr_t req_addr, rsp_addr;
    esd_row_t rows [9];
    int err_total = 0, cmp_count = 0, cyc = 0;
    esd_top u_dut (.clock(clock), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .req_valid(req_valid), .req_addr(req_addr), .req_sysmgmt_flag(req_sysmgmt_flag),
        .req_writeback(req_writeback), .rsp_valid(rsp_valid), .rsp_dram(rsp_dram), .rsp_io(rsp_io),
        .rsp_claimed(rsp_claimed), .rsp_addr(rsp_addr), .invalid_sysmgmt_access_flag(err_flag));
    esd_fsb_agent u_agt (.clock(clock), .req_valid(req_valid), .req_addr(req_addr),
        .req_sysmgmt_flag(req_sysmgmt_flag), .req_writeback(req_writeback));
    always #20 clock = ~clock;
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic chk(input string name, input esd_pkg::esd_addr_t got, input esd_pkg::esd_addr_t exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(input esd_pkg::esd_byte_t a, input esd_pkg::esd_byte_t d);
        @(posedge clock);
        cfg_wr_en <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clock);
        cfg_wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input esd_pkg::esd_byte_t a, input esd_pkg::esd_byte_t d);
        @(posedge clock);
        cfg_rd_en <= 1'b1;
        cfg_addr <= a;
        @(posedge clock);
        cfg_rd_en <= 1'b0;
        #1;
        chk("cfg_rvalid", 40'(cfg_rvalid), 40'h1);
        chk("cfg_rdata", 40'(cfg_rdata), 40'(d));
    endtask : rd
    task automatic req(input esd_pkg::esd_addr_t a, input logic f, input logic w, input logic [2:0] e,
                       input esd_pkg::esd_addr_t ea);
        u_agt.issue(a, f, w);
        #1;
        chk("rsp_valid", 40'(rsp_valid), 40'h1);
        chk("route", 40'({rsp_claimed, rsp_dram, rsp_io}), 40'(e));
        chk("rsp_addr", rsp_addr, ea);
    endtask : req
    initial begin
        rows[0] = '{40'h00000a0000, 1'b1, 1'b0, 3'b110, 40'h00000a0000};
        rows[1] = '{40'h00000bffff, 1'b0, 1'b0, 3'b101, 40'h00000bffff};
        rows[2] = '{40'h00feda0010, 1'b1, 1'b0, 3'b110, 40'h00000a0010};
        rows[3] = '{40'h00fedbffff, 1'b1, 1'b0, 3'b110, 40'h00000bffff};
        rows[4] = '{40'h000ff80000, 1'b1, 1'b0, 3'b110, 40'h000ff80000};
        rows[5] = '{40'h000ff7ffff, 1'b1, 1'b0, 3'b000, 40'h000ff7ffff};
        rows[6] = '{40'h0010000000, 1'b1, 1'b0, 3'b000, 40'h0010000000};
        rows[7] = '{40'h000fffffff, 1'b0, 1'b1, 3'b101, 40'h000fffffff};
        rows[8] = '{40'h010ff80000, 1'b1, 1'b0, 3'b000, 40'h010ff80000};
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rd(8'h62, 8'h00);
        rd(8'h63, 8'h01);
        rd(8'h64, 8'h00);
        wr(8'h62, 8'h89);
        for (int i = 0; i < 9; i++) req(rows[i].addr, rows[i].flag, rows[i].wb, rows[i].route, rows[i].exp_addr);
        $display("table done");
        chk("err_flag", 40'(err_flag), 40'h0);
        req(40'h000ff80000, 1'b0, 1'b0, 3'b101, 40'h000ff80000);
        chk("err_flag", 40'(err_flag), 40'h1);
        rd(8'h60, 8'h80);
        wr(8'h60, 8'h80);
        rd(8'h60, 8'h00);
        $display("error flag done");
        for (int s = 0; s < 4; s++) begin
            wr(8'h62, 8'h89 | 8'(s << 1));
            req(40'h0010000000 - (40'h80000 << s) - 40'h1, 1'b1, 1'b0, 3'b000, 40'h0010000000 - (40'h80000 << s) - 40'h1);
            req(40'h0010000000 - (40'h80000 << s), 1'b1, 1'b0, 3'b110, 40'h0010000000 - (40'h80000 << s));
        end
        $display("size done");
        wr(8'h62, 8'h89);
        wr(8'h63, 8'h02);
        req(40'h001fffffff, 1'b1, 1'b0, 3'b110, 40'h001fffffff);
        wr(8'h62, 8'hff);
        rd(8'h62, 8'h8f);
        wr(8'h62, 8'h81);
        req(40'h00feda0000, 1'b1, 1'b0, 3'b000, 40'h00feda0000);
        req(40'h001fffffff, 1'b1, 1'b0, 3'b000, 40'h001fffffff);
        // Global and high enable without segment enable must not decode the segment.
        wr(8'h62, 8'h88);
        req(40'h001fffffff, 1'b1, 1'b0, 3'b000, 40'h001fffffff);
        $display("enable gating done");
        wr(8'h62, 8'h89);
        wr(8'h61, 8'h40);
        req(40'h001fffffff, 1'b0, 1'b0, 3'b110, 40'h001fffffff);
        wr(8'h61, 8'h50);
        rd(8'h61, 8'h12);
        wr(8'h62, 8'h00);
        wr(8'h63, 8'h05);
        wr(8'h61, 8'h40);
        rd(8'h62, 8'h89);
        rd(8'h63, 8'h02);
        rd(8'h61, 8'h12);
        req(40'h001fffffff, 1'b0, 1'b0, 3'b101, 40'h001fffffff);
        $display("lock done");
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(8'h61, 8'h02);
        rd(8'h63, 8'h01);
        rd(8'h60, 8'h00);
        $display("reset done");
        end_sim();
    end
endmodule : extended_smram_decode_test
